// *** logic/ppr_regulator.sv ***
// process pid regulator: source selection, pid terms, filters, command
`timescale 1ns/1ps
`include "ppr_map.svh"

module ppr_regulator #(
  parameter int unsigned BEAT_CYCLES =
    `PPR_BEAT_TIME_NS / `PPR_CLOCK_PERIOD_NS
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_param_load,
  input wire logic [2:0] i_setpoint_source_sel,
  input wire logic [9:0] i_digital_setpoint,
  input wire logic [3:0] i_feedback_source_sel,
  input wire logic i_control_direction,
  input wire logic [15:0] i_display_range,
  input wire logic [9:0] i_prop_gain_set1,
  input wire logic [9:0] i_integral_time_set1,
  input wire logic [13:0] i_deriv_time_set1,
  input wire logic [9:0] i_prop_gain_set2,
  input wire logic [9:0] i_integral_time_set2,
  input wire logic [13:0] i_deriv_time_set2,
  input wire logic [15:0] i_reverse_cutoff_freq,
  input wire logic [13:0] i_deviation_deadband,
  input wire logic [15:0] i_setpoint_ramp_time,
  input wire logic [12:0] i_feedback_filter_time,
  input wire logic [12:0] i_output_filter_time,
  input wire logic [1:0] i_gain_switch_mode,
  input wire logic [3:0] i_main_freq_source_sel,
  input wire logic [3:0] i_aux_freq_source_sel,
  input wire logic [15:0] i_max_output_freq,
  input wire logic [15:0] i_analog_in_a,
  input wire logic [15:0] i_analog_in_b,
  input wire logic [15:0] i_comm_setpoint,
  input wire logic [15:0] i_multi_speed_setpoint,
  input wire logic [15:0] i_comm_feedback,
  input wire logic i_term_dir_invert,
  input wire logic i_term_gain_set2,
  output logic [15:0] o_freq_command,
  output logic o_freq_reverse,
  output logic o_pid_active,
  output logic o_beat,
  output logic [15:0] o_display_setpoint,
  output logic [15:0] o_display_feedback
);

  ppr_pkg::ppr_state_t st;
  ppr_pkg::ppr_state_t next;
  logic tick;
  logic active;
  logic signed [17:0] fb_raw;
  logic signed [17:0] fb_filt;
  logic signed [17:0] out_filt;
  logic signed [31:0] fa;
  logic signed [31:0] fbv;
  logic signed [31:0] fsel;
  logic signed [31:0] tgt;
  logic signed [31:0] fb;
  logic signed [31:0] err;
  logic signed [31:0] mag;
  logic signed [31:0] kp;
  logic signed [31:0] ti;
  logic signed [31:0] td;
  logic signed [31:0] p;
  logic signed [31:0] d;
  logic signed [31:0] integ;
  logic signed [31:0] u;
  logic signed [31:0] step;
  logic signed [31:0] sp_pct;
  logic signed [31:0] uf;
  logic signed [31:0] fq;
  logic dir_neg;
  logic set2;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic signed [31:0] ppr_clip(
    input logic signed [31:0] v,
    input logic signed [31:0] lo,
    input logic signed [31:0] hi
  );
    logic signed [31:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // unsigned input taken as percent and held inside full scale
  function automatic logic signed [31:0] ppr_pct(input logic [15:0] v);
    return ppr_clip($signed({16'h0000, v}), 32'sh00000000, `PPR_FULL_SCALE);
  endfunction

  // setting clamped into its allowed range on load
  function automatic logic [15:0] ppr_lim(
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [15:0] r;
    r = v;
    if (v < lo) begin
      r = lo;
    end else if (v > hi) begin
      r = hi;
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // beat and enable

  assign tick = (st.beat == 32'(BEAT_CYCLES - 1));
  assign active = (i_main_freq_source_sel == `PPR_FREQ_SRC_PID) ||
                  (i_aux_freq_source_sel == `PPR_FREQ_SRC_PID);

  ////////////////////////////////////////////////////////////////////////////
  // feedback source selection, ahead of the feedback filter

  always_comb begin
    fa = ppr_pct(i_analog_in_a);
    fbv = ppr_pct(i_analog_in_b);
    case (st.cfg.fb_src)
      `PPR_FB_AIN_A: fsel = fa;
      `PPR_FB_AIN_B: fsel = fbv;
      `PPR_FB_DIFF: fsel = ppr_clip(fa - fbv, 32'sh0, `PPR_FULL_SCALE);
      `PPR_FB_COMM: fsel = ppr_pct(i_comm_feedback);
      `PPR_FB_SUM: fsel = ppr_clip(fa + fbv, 32'sh0, `PPR_FULL_SCALE);
      `PPR_FB_MAX: fsel = (fa > fbv) ? fa : fbv;
      `PPR_FB_MIN: fsel = (fa < fbv) ? fa : fbv;
      default: fsel = 32'sh00000000;
    endcase
    fb_raw = 18'(fsel);
  end

  ppr_lowpass u_fb_filter (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_step(tick),
    .i_time(st.cfg.fb_filt),
    .i_sample(fb_raw),
    .o_value(fb_filt)
  );

  ppr_lowpass u_out_filter (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_step(st.phase == ppr_pkg::PPR_FILT),
    .i_time(st.cfg.out_filt),
    .i_sample(st.u),
    .o_value(out_filt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // regulator sequence: idle, compute terms, filter output, form command

  always_comb begin
    next = st;
    tgt = 32'sh0;
    fb = ppr_clip(32'(fb_filt), 32'sh0, `PPR_FULL_SCALE);
    err = 32'sh0;
    mag = 32'sh0;
    kp = 32'sh0;
    ti = 32'sh1;
    td = 32'sh0;
    p = 32'sh0;
    d = 32'sh0;
    integ = st.integ;
    u = 32'sh0;
    step = 32'sh0;
    uf = 32'(out_filt);
    fq = 32'sh0;
    dir_neg = st.cfg.dir ^ i_term_dir_invert;
    set2 = (i_gain_switch_mode == `PPR_GSW_TERMINAL) &&
           i_term_gain_set2;
    sp_pct = st.sp_eff >>> `PPR_Q16_SHIFT;
    next.beat = tick ? 32'h0 : st.beat + 32'h1;
    case (st.phase)
      ppr_pkg::PPR_IDLE: begin
        if (tick) begin
          next.phase = ppr_pkg::PPR_CALC;
        end
      end
      ppr_pkg::PPR_CALC: begin
        case (st.cfg.sp_src)
          `PPR_SP_DIGITAL: tgt = $signed({22'h0, st.cfg.dig_sp}) *
                                 32'sha;
          `PPR_SP_AIN_A: tgt = ppr_pct(i_analog_in_a);
          `PPR_SP_AIN_B: tgt = ppr_pct(i_analog_in_b);
          `PPR_SP_COMM: tgt = ppr_pct(i_comm_setpoint);
          `PPR_SP_MULTI: tgt = ppr_pct(i_multi_speed_setpoint);
          default: tgt = 32'sh0;
        endcase
        // ramp kept in q16 so slow ramps still move every beat
        tgt = tgt <<< `PPR_Q16_SHIFT;
        if (st.cfg.ramp == 16'h0) begin
          next.sp_eff = tgt;
        end else begin
          step = (`PPR_FULL_SCALE <<< `PPR_Q16_SHIFT) /
                 ($signed({16'h0, st.cfg.ramp}) * `PPR_TI_BEATS);
          if (step < 32'sh1) begin
            step = 32'sh1;
          end
          if (tgt > st.sp_eff + step) begin
            next.sp_eff = st.sp_eff + step;
          end else if (tgt < st.sp_eff - step) begin
            next.sp_eff = st.sp_eff - step;
          end else begin
            next.sp_eff = tgt;
          end
        end
        // error and display use this beat's setpoint, so ramp 0 is immediate
        sp_pct = next.sp_eff >>> `PPR_Q16_SHIFT;
        // positive error always means raise the output
        err = dir_neg ? fb - sp_pct : sp_pct - fb;
        kp = $signed({22'h0, set2 ? st.cfg.kp2 : st.cfg.kp1});
        ti = $signed({22'h0, set2 ? st.cfg.ti2 : st.cfg.ti1});
        td = $signed({18'h0, set2 ? st.cfg.td2 : st.cfg.td1});
        mag = (err < 32'sh0) ? -err : err;
        if (!active) begin
          next.integ = 32'sh0;
          next.u = 18'sh0;
        end else if (mag > $signed({18'h0, st.cfg.deadband})) begin
          p = kp * err / `PPR_GAIN_DIV;
          integ = st.integ + (err <<< `PPR_Q16_SHIFT) /
                  (ti * `PPR_TI_BEATS);
          integ = ppr_clip(integ, -(`PPR_FULL_SCALE <<< `PPR_Q16_SHIFT),
                           `PPR_FULL_SCALE <<< `PPR_Q16_SHIFT);
          d = td * (err - st.e_prev) / `PPR_TD_BEAT_MS;
          u = p + (integ >>> `PPR_Q16_SHIFT) + d;
          u = ppr_clip(u, -`PPR_FULL_SCALE, `PPR_FULL_SCALE);
          next.integ = integ;
          next.u = 18'(u);
        end
        next.e_prev = err;
        next.disp_sp = 16'(sp_pct * $signed({16'h0, st.cfg.range}) /
                           `PPR_FULL_SCALE);
        next.disp_fb = 16'(fb * $signed({16'h0, st.cfg.range}) /
                           `PPR_FULL_SCALE);
        next.phase = ppr_pkg::PPR_FILT;
      end
      ppr_pkg::PPR_FILT: begin
        next.phase = ppr_pkg::PPR_FREQ;
      end
      ppr_pkg::PPR_FREQ: begin
        // a reverse command only exists when the cut-off allows it
        mag = (uf < 32'sh0) ? -uf : uf;
        fq = mag * $signed({16'h0, i_max_output_freq}) / `PPR_FULL_SCALE;
        fq = ppr_clip(fq, 32'sh0, $signed({16'h0, i_max_output_freq}));
        if (uf < 32'sh0) begin
          fq = ppr_clip(fq, 32'sh0, $signed({16'h0, st.cfg.cutoff}));
        end
        if (!active) begin
          fq = 32'sh0;
        end
        next.freq = 16'(fq);
        next.rev = (uf < 32'sh0) && (fq != 32'sh0);
        next.phase = ppr_pkg::PPR_IDLE;
      end
      default: begin
        next.phase = ppr_pkg::PPR_IDLE;
      end
    endcase
    ////////////////////////////////////////////////////////////////////////////
    // settings are captured on load; all but the source codes, direction, range and cutoff are clipped into their ranges
    if (i_param_load) begin
      next.cfg.sp_src = i_setpoint_source_sel;
      next.cfg.dig_sp = 10'(ppr_lim(16'(i_digital_setpoint), 16'h0,
                                    `PPR_DIG_SP_MAX));
      next.cfg.fb_src = i_feedback_source_sel;
      next.cfg.dir = i_control_direction;
      next.cfg.range = i_display_range;
      next.cfg.kp1 = 10'(ppr_lim(16'(i_prop_gain_set1), 16'h0,
                                 `PPR_GAIN_MAX));
      next.cfg.ti1 = 10'(ppr_lim(16'(i_integral_time_set1), `PPR_TI_MIN,
                                 `PPR_TI_MAX));
      next.cfg.td1 = 14'(ppr_lim(16'(i_deriv_time_set1), 16'h0,
                                 `PPR_TD_MAX));
      next.cfg.kp2 = 10'(ppr_lim(16'(i_prop_gain_set2), 16'h0,
                                 `PPR_GAIN_MAX));
      next.cfg.ti2 = 10'(ppr_lim(16'(i_integral_time_set2), `PPR_TI_MIN,
                                 `PPR_TI_MAX));
      next.cfg.td2 = 14'(ppr_lim(16'(i_deriv_time_set2), 16'h0,
                                 `PPR_TD_MAX));
      next.cfg.cutoff = i_reverse_cutoff_freq;
      next.cfg.deadband = 14'(ppr_lim(16'(i_deviation_deadband), 16'h0,
                                      `PPR_DEADBAND_MAX));
      next.cfg.ramp = ppr_lim(i_setpoint_ramp_time, 16'h0, `PPR_RAMP_MAX);
      next.cfg.fb_filt = 13'(ppr_lim(16'(i_feedback_filter_time), 16'h0,
                                     `PPR_FILT_MAX));
      next.cfg.out_filt = 13'(ppr_lim(16'(i_output_filter_time), 16'h0,
                                      `PPR_FILT_MAX));
    end
    ////////////////////////////////////////////////////////////////////////////
    // synchronous reset to the documented defaults
    if (!i_reset_n) begin
      next = '0;
      next.phase = ppr_pkg::PPR_IDLE;
      next.cfg.dig_sp = `PPR_DIG_SP_RESET;
      next.cfg.range = `PPR_RANGE_RESET;
      next.cfg.kp1 = `PPR_GAIN_RESET;
      next.cfg.ti1 = `PPR_TI_RESET;
      next.cfg.td1 = `PPR_TD_RESET;
      next.cfg.kp2 = `PPR_GAIN_RESET;
      next.cfg.ti2 = `PPR_TI_RESET;
      next.cfg.td2 = `PPR_TD_RESET;
      next.cfg.deadband = `PPR_DEADBAND_RESET;
    end
  end

  always_ff @(posedge i_clock) begin
    st <= next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign o_freq_command = st.freq;
  assign o_freq_reverse = st.rev;
  assign o_pid_active = active;
  assign o_beat = tick;
  assign o_display_setpoint = st.disp_sp;
  assign o_display_feedback = st.disp_fb;

endmodule

// *** logic/ppr_map.svh ***
// constants of the process pid regulator: codes, defaults, limits, timing
`ifndef PPR_MAP_SVH
`define PPR_MAP_SVH

// timing
`define PPR_CLOCK_PERIOD_NS 32'h0000000a
`define PPR_BEAT_TIME_NS 32'h001e8480

// percent values are in 0.01 % steps, full scale is 100.00 %
`define PPR_FULL_SCALE 32'sh00002710
`define PPR_ONE_Q16 32'sh00010000
`define PPR_Q16_SHIFT 16

// setpoint source codes
`define PPR_SP_DIGITAL 3'h0
`define PPR_SP_AIN_A 3'h1
`define PPR_SP_AIN_B 3'h2
`define PPR_SP_COMM 3'h5
`define PPR_SP_MULTI 3'h6

// feedback source codes
`define PPR_FB_AIN_A 4'h0
`define PPR_FB_AIN_B 4'h1
`define PPR_FB_DIFF 4'h3
`define PPR_FB_COMM 4'h5
`define PPR_FB_SUM 4'h6
`define PPR_FB_MAX 4'h7
`define PPR_FB_MIN 4'h8

// frequency source code that hands the command to the regulator
`define PPR_FREQ_SRC_PID 4'h8

// gain-set switching modes
`define PPR_GSW_TERMINAL 2'h1

// reset values
`define PPR_DIG_SP_RESET 10'h1f4
`define PPR_GAIN_RESET 10'h0c8
`define PPR_TI_RESET 10'h0c8
`define PPR_TD_RESET 14'h0000
`define PPR_DEADBAND_RESET 14'h0001
`define PPR_RANGE_RESET 16'h03e8

// load limits
`define PPR_DIG_SP_MAX 16'h03e8
`define PPR_GAIN_MAX 16'h03e8
`define PPR_TI_MIN 16'h0001
`define PPR_TI_MAX 16'h03e8
`define PPR_TD_MAX 16'h2710
`define PPR_DEADBAND_MAX 16'h2710
`define PPR_RAMP_MAX 16'hfde8
`define PPR_FILT_MAX 16'h1770

// scale factors of the terms
`define PPR_GAIN_DIV 32'sh000003e8
`define PPR_TI_BEATS 32'sh00000005
`define PPR_TD_BEAT_MS 32'sh00000002

`endif

// *** logic/ppr_pkg.sv ***
// types of the process pid regulator
package ppr_pkg;

  typedef enum logic [3:0] {
    PPR_IDLE = 4'h1,
    PPR_CALC = 4'h2,
    PPR_FILT = 4'h4,
    PPR_FREQ = 4'h8
  } ppr_phase_t;

  typedef struct packed {
    logic [2:0] sp_src;
    logic [9:0] dig_sp;
    logic [3:0] fb_src;
    logic dir;
    logic [15:0] range;
    logic [9:0] kp1;
    logic [9:0] ti1;
    logic [13:0] td1;
    logic [9:0] kp2;
    logic [9:0] ti2;
    logic [13:0] td2;
    logic [15:0] cutoff;
    logic [13:0] deadband;
    logic [15:0] ramp;
    logic [12:0] fb_filt;
    logic [12:0] out_filt;
  } ppr_cfg_t;

  typedef struct packed {
    ppr_phase_t phase;
    logic [31:0] beat;
    ppr_cfg_t cfg;
    logic signed [31:0] sp_eff;
    logic signed [31:0] integ;
    logic signed [31:0] e_prev;
    logic signed [17:0] u;
    logic [15:0] freq;
    logic rev;
    logic [15:0] disp_sp;
    logic [15:0] disp_fb;
  } ppr_state_t;

  typedef struct packed {
    logic signed [33:0] acc;
  } ppr_lpf_t;

endpackage

// *** logic/ppr_lowpass.sv ***
// first-order low-pass stage stepped once per control beat
`timescale 1ns/1ps
`include "ppr_map.svh"

module ppr_lowpass (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_step,
  input wire logic [12:0] i_time,
  input wire logic signed [17:0] i_sample,
  output logic signed [17:0] o_value
);

  ppr_pkg::ppr_lpf_t st;
  ppr_pkg::ppr_lpf_t next;
  logic signed [35:0] diff;
  logic signed [35:0] den;

  ////////////////////////////////////////////////////////////////////////////
  // time in 10 ms steps, beat is 2 ms: weight is 1 / (5 * time + 1)
  always_comb begin
    next = st;
    diff = (36'(i_sample) <<< `PPR_Q16_SHIFT) - 36'(st.acc);
    den = $signed({23'h000000, i_time}) * 36'sh000000005 + 36'sh000000001;
    if (i_step) begin
      if (i_time == 13'h0000) begin
        next.acc = 34'(36'(i_sample) <<< `PPR_Q16_SHIFT);
      end else begin
        next.acc = 34'(36'(st.acc) + diff / den);
      end
    end
    if (!i_reset_n) begin
      next.acc = 34'sh000000000;
    end
  end

  always_ff @(posedge i_clock) begin
    st <= next;
  end

  assign o_value = st.acc[33:16];

endmodule

// *** sim/ppr_regulator_monitor.sv ***
// assertion checker bound to the process pid regulator ports
`timescale 1ns/1ps
module ppr_regulator_monitor #(
  parameter int unsigned BEAT_CYCLES = 8
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic [3:0] i_main_freq_source_sel,
  input wire logic [3:0] i_aux_freq_source_sel,
  input wire logic [15:0] i_max_output_freq,
  input wire logic [15:0] i_reverse_cutoff_freq,
  input wire logic [15:0] i_display_range,
  input wire logic [15:0] o_freq_command,
  input wire logic o_freq_reverse,
  input wire logic o_pid_active,
  input wire logic o_beat,
  input wire logic [15:0] o_display_setpoint,
  input wire logic [15:0] o_display_feedback
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  ////////////////////////////////////////////////////////////
  // counted here: a beat is far too long for a repetition
  logic [31:0] since;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n || o_beat) begin
      since <= '0;
    end else begin
      since <= since + 32'h00000001;
    end
  end
  ////////////////////////////////////////////////////////////
  AST_BEAT_SPACING: assert property
    (o_beat |-> since == BEAT_CYCLES - 1)
    else $error("beat pulse off its period");
  AST_BEAT_MISSING: assert property (since < BEAT_CYCLES)
    else $error("beat pulse missing");
  AST_ACTIVE_SOURCE: assert property (o_pid_active ==
    (i_main_freq_source_sel == 4'h8 || i_aux_freq_source_sel == 4'h8))
    else $error("active flag does not follow sources");
  AST_CMD_TIMING: assert property
    ($changed(o_freq_command) || $changed(o_freq_reverse) |-> $past(o_beat, 4))
    else $error("command moved outside its beat slot");
  AST_DISP_TIMING: assert property
    ($changed(o_display_setpoint) || $changed(o_display_feedback)
      |-> $past(o_beat, 2))
    else $error("display moved outside its beat slot");
  AST_CMD_MAX: assert property
    ($changed(o_freq_command) |-> o_freq_command <= $past(i_max_output_freq))
    else $error("command above maximum");
  AST_REV_CUTOFF: assert property (o_freq_reverse |->
    o_freq_command <= i_reverse_cutoff_freq && o_freq_command != 16'h0000)
    else $error("reverse command outside cut-off");
  AST_IDLE_ZERO: assert property
    ((o_beat && !o_pid_active) ##1 (!o_pid_active) [*3]
      |=> o_freq_command == 16'h0000)
    else $error("command while regulator unused");
  AST_DISP_RANGE: assert property ($changed(o_display_setpoint) |->
    o_display_setpoint <= i_display_range &&
    o_display_feedback <= i_display_range)
    else $error("display beyond range");
endmodule
bind ppr_regulator ppr_regulator_monitor #(
  .BEAT_CYCLES(BEAT_CYCLES)
) u_mon (.*);

// *** sim/ppr_feedback_model.sv ***
// analog feedback source model in front of the regulator inputs
`timescale 1ns/1ps
module ppr_feedback_model (
  input wire logic i_clock,
  input wire logic [15:0] i_level_a,
  input wire logic [15:0] i_level_b,
  output logic [15:0] o_analog_in_a,
  output logic [15:0] o_analog_in_b
);
  // one cycle of conversion latency, like a sampled converter
  always_ff @(posedge i_clock) begin
    o_analog_in_a <= i_level_a;
    o_analog_in_b <= i_level_b;
  end
endmodule

// *** sim/ppr_regulator_test.sv ***
// self-checking bench for the process pid regulator
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("wrong value %s exp %0d got %0d", n, e, g); \
  end \
end
module ppr_regulator_test;
  logic i_clock, i_reset_n, i_param_load, i_control_direction;
  logic i_term_dir_invert, i_term_gain_set2, o_freq_reverse;
  logic o_pid_active, o_beat;
  logic [1:0] i_gain_switch_mode;
  logic [2:0] i_setpoint_source_sel;
  logic [3:0] i_feedback_source_sel, i_main_freq_source_sel;
  logic [3:0] i_aux_freq_source_sel;
  logic [9:0] i_digital_setpoint, i_prop_gain_set1, i_prop_gain_set2;
  logic [9:0] i_integral_time_set1, i_integral_time_set2;
  logic [12:0] i_feedback_filter_time, i_output_filter_time;
  logic [13:0] i_deriv_time_set1, i_deriv_time_set2, i_deviation_deadband;
  logic [15:0] i_display_range, i_reverse_cutoff_freq, i_max_output_freq;
  logic [15:0] i_setpoint_ramp_time, i_comm_setpoint, i_comm_feedback;
  logic [15:0] i_multi_speed_setpoint, i_analog_in_a, i_analog_in_b;
  logic [15:0] o_freq_command, o_display_setpoint, o_display_feedback;
  logic [15:0] lvl_a, lvl_b;
  int mismatches, num_checks;
  ////////////////////////////////////////////////////////////
  ppr_feedback_model partner (.i_clock(i_clock), .i_level_a(lvl_a),
    .i_level_b(lvl_b), .o_analog_in_a(i_analog_in_a),
    .o_analog_in_b(i_analog_in_b));
  // short beat keeps the run brief; all figures below assume 8 cycles
  ppr_regulator #(.BEAT_CYCLES(8)) dut (.*);
  always #5 i_clock = ~i_clock;
  ////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask
  task automatic load;
    i_param_load = 1'b1;
    tick();
    i_param_load = 1'b0;
  endtask
  task automatic set_defaults;
    i_param_load = 1'b0;
    i_setpoint_source_sel = 3'h0;
    i_digital_setpoint = 10'h1f4;
    i_feedback_source_sel = 4'h0;
    i_control_direction = 1'b0;
    i_display_range = 16'h03e8;
    i_prop_gain_set1 = 10'h0c8;
    i_prop_gain_set2 = 10'h0c8;
    i_integral_time_set1 = 10'h0c8;
    i_integral_time_set2 = 10'h0c8;
    i_deriv_time_set1 = 14'h0000;
    i_deriv_time_set2 = 14'h0000;
    i_reverse_cutoff_freq = 16'h0000;
    i_deviation_deadband = 14'h0001;
    i_setpoint_ramp_time = 16'h0000;
    i_feedback_filter_time = 13'h0000;
    i_output_filter_time = 13'h0000;
    i_gain_switch_mode = 2'h0;
    i_main_freq_source_sel = 4'h8;
    i_aux_freq_source_sel = 4'h0;
    i_max_output_freq = 16'h1388;
    i_comm_setpoint = 16'h0000;
    i_multi_speed_setpoint = 16'h0000;
    i_comm_feedback = 16'h0000;
    i_term_dir_invert = 1'b0;
    i_term_gain_set2 = 1'b0;
    lvl_a = 16'h07d0;
    lvl_b = 16'h0000;
  endtask
  task automatic restart;
    set_defaults();
    i_reset_n = 1'b0;
    repeat (16) tick();
    i_reset_n = 1'b1;
  endtask
  // wait for the beat pulse, then for the command it launches
  task automatic beat;
    int k;
    k = 0;
    while (o_beat !== 1'b1) begin
      tick();
      k++;
      if (k > 20) begin
        mismatches++;
        final_report();
      end
    end
    repeat (4) tick();
  endtask
  function automatic logic [15:0] fcmd(input int u);
    return 16'(u * int'(i_max_output_freq) / 10000);
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_direction;
    logic rev;
    for (int i = 0; i < 4; i++) begin
      restart();
      i_control_direction = i[0];
      i_term_dir_invert = i[1];
      i_reverse_cutoff_freq = 16'h0064;
      load();
      beat();
      rev = i[0] ^ i[1];
      `CHK("reverse", rev, o_freq_reverse)
      `CHK("command", rev ? 16'h0064 : fcmd(603), o_freq_command)
    end
  endtask
  task automatic t_gain_sets;
    for (int i = 0; i < 3; i++) begin
      restart();
      i_prop_gain_set2 = 10'h3e8;
      i_gain_switch_mode = (i == 2) ? 2'h0 : 2'h1;
      i_term_gain_set2 = (i != 0);
      load();
      beat();
      `CHK("gain set", fcmd(i == 1 ? 3003 : 603), o_freq_command)
    end
  endtask
  task automatic t_deadband;
    restart();
    i_deviation_deadband = 14'h0bb8;
    load();
    beat();
    `CHK("held command", 16'h0000, o_freq_command)
    i_deviation_deadband = 14'h0bb7;
    load();
    beat();
    `CHK("free command", fcmd(603), o_freq_command)
  endtask
  task automatic t_sources;
    int sp[9] = '{1000, 600, 200, 0, 0, 400, 800, 0, 1000};
    int fb[9] = '{600, 200, 0, 400, 0, 400, 800, 600, 200};
    restart();
    lvl_a = 16'h0bb8;
    lvl_b = 16'h03e8;
    i_comm_feedback = 16'h07d0;
    i_comm_setpoint = 16'h07d0;
    i_multi_speed_setpoint = 16'h0fa0;
    i_display_range = 16'h07d0;
    for (int i = 0; i < 9; i++) begin
      i_setpoint_source_sel = 3'(i);
      i_feedback_source_sel = 4'(i);
      load();
      beat();
      `CHK("setpoint source", 16'(sp[i]), o_display_setpoint)
      `CHK("feedback source", 16'(fb[i]), o_display_feedback)
    end
  endtask
  task automatic t_int_deriv;
    restart();
    i_prop_gain_set1 = 10'h000;
    i_integral_time_set1 = 10'h001;
    i_deriv_time_set1 = 14'h0002;
    load();
    beat();
    `CHK("i plus d", fcmd(3600), o_freq_command)
    beat();
    `CHK("i only", fcmd(1200), o_freq_command)
  endtask
  task automatic t_ramp_filter;
    restart();
    i_setpoint_ramp_time = 16'h000a;
    i_feedback_filter_time = 13'h0001;
    lvl_a = 16'h1770;
    load();
    beat();
    `CHK("ramp 1", 16'h0014, o_display_setpoint)
    `CHK("filter 1", 16'h0064, o_display_feedback)
    beat();
    `CHK("ramp 2", 16'h0028, o_display_setpoint)
    `CHK("filter 2", 16'h00b7, o_display_feedback)
  endtask
  task automatic t_inactive;
    restart();
    // reset defaults alone give a live command before the source drops
    beat();
    `CHK("default command", fcmd(603), o_freq_command)
    i_main_freq_source_sel = 4'h0;
    tick();
    `CHK("active flag", 1'b0, o_pid_active)
    beat();
    `CHK("idle command", 16'h0000, o_freq_command)
    i_aux_freq_source_sel = 4'h8;
    tick();
    `CHK("active flag", 1'b1, o_pid_active)
    beat();
    `CHK("aux command", fcmd(603), o_freq_command)
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    mismatches = 0;
    num_checks = 0;
    t_direction();
    t_gain_sets();
    t_deadband();
    t_sources();
    t_int_deriv();
    t_ramp_filter();
    t_inactive();
    final_report();
  end
endmodule
